// ### rtl/dcr1_control.sv
// What this block does
// - Decode addresses 0x00 to 0x10, skip 0x05.
// - Staged writes move on update strobe.
// - Control register at 0x00, 32 bits.
// - Bit 0 is least significant bit.
// - Bit 28 selects sweep or modulus.
// - Bit 27 chooses internal profile, else pins in serial mode, else 000.
// - Bits 22:20 internal profile, default 000.
// - Bit 26 unmatches pipeline latencies.
// - Bit 23 selects serial bit order.
// - Bit 19 holds sync clock low, undriven.
// - Bit 16 enables direct switch mode.
// - Bit 15 holds auxiliary accumulator reset.
// - Aux clear aligns to update, sync edge.
// - Bit 14 holds phase accumulator reset.
`timescale 1ns/10ps
module dcr1_control
    import dcr1_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [4:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             reg_addr_valid,
    input  wire logic        io_update,
    input  wire logic [2:0]  profile_pins,
    input  wire logic        serial_mode,
    output logic      [2:0]  active_profile,
    output logic             aux_modulus,
    output logic             pipe_unmatched,
    output logic             lsb_first,
    output logic             direct_switch,
    output logic             aux_acc_clear,
    output logic             phase_acc_clear,
    output logic             sync_clk_out,
    output logic             sync_clk_oe
);
    // Addresses 0x01 to 0x10 other than 0x05 answer as valid but hold zero.
    function automatic logic addr_ok(input logic [4:0] a);
        addr_ok = (a <= DCR1_ADDR_LAST) && (a != DCR1_ADDR_UNUSED);
    endfunction

    logic [31:0] stage_reg, stage_next;
    logic [31:0] live_reg, live_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  upd_s_reg, upd_s_next;
    logic [2:0]  pin_s1_reg, pin_s1_next, pin_s2_reg, pin_s2_next;
    logic        upd_d_reg, upd_d_next;
    logic        sync_reg, sync_next;
    logic        clr_pend_reg, clr_pend_next;
    logic        aux_clr_reg, aux_clr_next;
    logic [2:0]  prof_d_reg, prof_d_next;
    logic        upd_pulse;
    logic        prof_change;

    assign upd_pulse = upd_s_reg[1] && !upd_d_reg;

    always_comb begin
        upd_s_next  = {upd_s_reg[0], io_update};
        upd_d_next  = upd_s_reg[1];
        pin_s1_next = profile_pins;
        pin_s2_next = pin_s1_reg;
        stage_next  = stage_reg;
        live_next   = live_reg;
        rdata_next  = rdata_reg;
        // Writes to the unused address fall through untouched.
        if (reg_wr && reg_addr == DCR1_ADDR_CONTROL_FUNCTION_ONE) begin
            // Open bits are stored as the host wrote them.
            stage_next = reg_wdata;
        end
        if (upd_pulse) begin
            live_next = stage_reg;
        end
        if (reg_rd) begin
            if (reg_addr == DCR1_ADDR_CONTROL_FUNCTION_ONE) begin
                rdata_next = stage_reg;
            end else begin
                rdata_next = 32'h0000_0000;
            end
        end
    end

    // Selected profile, pins only honoured in serial mode.
    always_comb begin
        if (live_reg[DCR1_BIT_INT_PROFILE]) begin
            active_profile = live_reg[DCR1_PROF_HI:DCR1_PROF_LO];
        end else if (serial_mode) begin
            active_profile = pin_s2_reg;
        end else begin
            active_profile = 3'h0;
        end
    end

    assign prof_change = (active_profile != prof_d_reg);

    // Sync clock is clk divided by two; the aux clear only moves on its
    // rising edge after an update or profile change, so software cannot
    // glitch the accumulator mid-cycle.
    always_comb begin
        sync_next     = !sync_reg;
        prof_d_next   = active_profile;
        clr_pend_next = clr_pend_reg;
        aux_clr_next  = aux_clr_reg;
        if (upd_pulse || prof_change) begin
            clr_pend_next = 1'b1;
        end else if (clr_pend_reg && !sync_reg) begin
            clr_pend_next = 1'b0;
        end
        if (clr_pend_reg && !sync_reg) begin
            aux_clr_next = live_reg[DCR1_BIT_CLR_AUX];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage_reg    <= DCR1_CFO_RESET;
            live_reg     <= DCR1_CFO_RESET;
            rdata_reg    <= 32'h0000_0000;
            upd_s_reg    <= 2'h0;
            upd_d_reg    <= 1'b0;
            pin_s1_reg   <= 3'h0;
            pin_s2_reg   <= 3'h0;
            sync_reg     <= 1'b0;
            clr_pend_reg <= 1'b0;
            aux_clr_reg  <= 1'b0;
            prof_d_reg   <= 3'h0;
        end else begin
            stage_reg    <= stage_next;
            live_reg     <= live_next;
            rdata_reg    <= rdata_next;
            upd_s_reg    <= upd_s_next;
            upd_d_reg    <= upd_d_next;
            pin_s1_reg   <= pin_s1_next;
            pin_s2_reg   <= pin_s2_next;
            sync_reg     <= sync_next;
            clr_pend_reg <= clr_pend_next;
            aux_clr_reg  <= aux_clr_next;
            prof_d_reg   <= prof_d_next;
        end
    end

    assign reg_rdata       = rdata_reg;
    assign reg_addr_valid  = addr_ok(reg_addr);
    assign aux_modulus     = live_reg[DCR1_BIT_MODULUS];
    assign pipe_unmatched  = live_reg[DCR1_BIT_PIPE_UNMATCHED];
    // Order takes effect after update; the serial shifter reads it.
    assign lsb_first       = live_reg[DCR1_BIT_LSB_FIRST];
    assign direct_switch   = live_reg[DCR1_BIT_DIRECT_SWITCH];
    assign aux_acc_clear   = aux_clr_reg;
    assign phase_acc_clear = live_reg[DCR1_BIT_CLR_PHASE];
    assign sync_clk_out    = sync_reg && !live_reg[DCR1_BIT_SYNC_DISABLE];
    assign sync_clk_oe     = !live_reg[DCR1_BIT_SYNC_DISABLE];
endmodule

// ### shared/dcr1_pkg.sv
package dcr1_pkg;
    localparam logic [4:0]  DCR1_ADDR_CONTROL_FUNCTION_ONE = 5'h00;
    localparam logic [4:0]  DCR1_ADDR_UNUSED               = 5'h05;
    localparam logic [4:0]  DCR1_ADDR_LAST                 = 5'h10;
    localparam int          DCR1_CFO_BYTES                 = 4;
    localparam logic [31:0] DCR1_CFO_RESET                 = 32'h0000_0000;
    localparam int          DCR1_BIT_MODULUS               = 28;
    localparam int          DCR1_BIT_INT_PROFILE           = 27;
    localparam int          DCR1_BIT_PIPE_UNMATCHED        = 26;
    localparam int          DCR1_BIT_LSB_FIRST             = 23;
    localparam int          DCR1_PROF_HI                   = 22;
    localparam int          DCR1_PROF_LO                   = 20;
    localparam int          DCR1_BIT_SYNC_DISABLE          = 19;
    localparam int          DCR1_BIT_DIRECT_SWITCH         = 16;
    localparam int          DCR1_BIT_CLR_AUX               = 15;
    localparam int          DCR1_BIT_CLR_PHASE             = 14;
    localparam logic [31:0] DCR1_OPEN_MASK                 = 32'hE306_0000;
endpackage

// ### testbench/dcr1_control_chk.sv
`timescale 1ns/10ps
module dcr1_control_chk (
    input wire logic        clk, resetn, reg_rd, reg_addr_valid, io_update,
    input wire logic        serial_mode, aux_modulus, pipe_unmatched,
    input wire logic        lsb_first, direct_switch, aux_acc_clear,
    input wire logic        phase_acc_clear, sync_clk_out, sync_clk_oe,
    input wire logic [4:0]  reg_addr,
    input wire logic [31:0] reg_rdata,
    input wire logic [2:0]  active_profile
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Update pin rose three edges back, through two sync flops and a detect.
    sequence s_upd; $past(io_update, 3) && !$past(io_update, 4); endsequence
    property p_valid; reg_addr_valid == (reg_addr <= 5'h10 &&
        reg_addr != 5'h05); endproperty
    a_valid: assert property (p_valid) else $error("decode");
    property p_rd_zero; reg_rd && reg_addr != 5'h00 |=>
        reg_rdata == 32'h0; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("rd zero");
    property p_rd_hold; $changed(reg_rdata) |-> $past(reg_rd); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("rd hold");
    property p_sync_off; !sync_clk_oe |-> !sync_clk_out; endproperty
    a_sync_off: assert property (p_sync_off) else $error("sync");
    property p_toggle; $past(resetn) && sync_clk_oe && $past(sync_clk_oe) |->
        sync_clk_out != $past(sync_clk_out); endproperty
    a_toggle: assert property (p_toggle) else $error("toggle");
    property p_live; $changed({aux_modulus, pipe_unmatched, lsb_first,
        direct_switch, phase_acc_clear, sync_clk_oe}) |-> s_upd; endproperty
    a_live: assert property (p_live) else $error("live");
    property p_prof; !serial_mode && $stable(serial_mode) &&
        $changed(active_profile) |-> s_upd; endproperty
    a_prof: assert property (p_prof) else $error("profile");
    property p_aux; sync_clk_oe && $changed(aux_acc_clear) |->
        $rose(sync_clk_out); endproperty
    a_aux: assert property (p_aux) else $error("aux clear");
endmodule
bind dcr1_control dcr1_control_chk chk (.*);

// ### testbench/dcr1_host.sv
`timescale 1ns/10ps
module dcr1_host
    import dcr1_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [31:0] reg_rdata,
    output logic      [4:0]  reg_addr,
    output logic             reg_wr, reg_rd, io_update,
    output logic      [31:0] reg_wdata
);
    initial {reg_addr, reg_wr, reg_rd, io_update, reg_wdata} = '0;
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(negedge clk);
        {reg_addr, reg_wdata, reg_wr} = {a, v & ~DCR1_OPEN_MASK, 1'b1};
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~reg_wdata;
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] v);
        @(negedge clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge clk);
        reg_rd = 1'b0;
        v = reg_rdata;
    endtask
    // Waits long enough for the aux clear to meet a sync rising edge too.
    task automatic upd;
        @(negedge clk);
        io_update = 1'b1;
        repeat (2) @(negedge clk);
        io_update = 1'b0;
        repeat (4) @(negedge clk);
    endtask
endmodule

// ### testbench/test_dcr1_control.sv
`timescale 1ns/10ps
module test_dcr1_control
    import dcr1_pkg::*;
;
    logic clk = 0, resetn = 0, serial_mode = 0, reg_wr, reg_rd, io_update;
    logic reg_addr_valid, aux_modulus, pipe_unmatched, lsb_first, s0;
    logic direct_switch, aux_acc_clear, phase_acc_clear, sync_clk_out;
    logic sync_clk_oe;
    logic [2:0] profile_pins = '0, active_profile;
    logic [4:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    int fail_count = 0, check_count = 0;
    always #20 clk = ~clk;
    dcr1_host host (.*);
    dcr1_control uut (.*);
    task chk(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task print_verdict;
        if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task t_stage;
        host.rd(5'h00, d);
        chk("reset", 32'h0, d);
        host.wr(5'h00, 32'h14D9_C000);
        host.wr(5'h05, 32'hFFFF_FFFF);
        chk("staged", 32'h1, {lsb_first, sync_clk_oe});
        for (int a = 0; a < 32; a++) begin
            host.rd(a[4:0], d);
            chk("valid", (a <= 16 && a != 5), reg_addr_valid);
            chk("rdata", a == 0 ? 32'h14D9_C000 : 32'h0, d);
        end
    endtask
    task t_live;
        {serial_mode, profile_pins} = 4'hB;
        host.upd;
        chk("live1", 11'h7E3, {aux_modulus, pipe_unmatched, lsb_first,
            direct_switch, phase_acc_clear, aux_acc_clear, sync_clk_oe,
            sync_clk_out, active_profile});
        serial_mode = 1'b0;
        host.wr(5'h00, 32'h0850_0000);
        host.upd;
        chk("live2", 10'h00D, {aux_modulus, pipe_unmatched, lsb_first,
            direct_switch, phase_acc_clear, aux_acc_clear, sync_clk_oe,
            active_profile});
        s0 = sync_clk_out;
        @(negedge clk);
        chk("toggle", 32'h1, s0 ^ sync_clk_out);
    endtask
    // A second reset in mid-run must clear both staged and live copies.
    task t_reset;
        resetn = 1'b0;
        @(negedge clk);
        resetn = 1'b1;
        chk("rst_out", 10'h008, {aux_modulus, pipe_unmatched, lsb_first,
            direct_switch, phase_acc_clear, aux_acc_clear, sync_clk_oe,
            active_profile});
        host.rd(5'h00, d);
        chk("rst_rd", 32'h0, d);
    endtask
    initial begin
        #100000;
        fail_count++;
        print_verdict;
    end
    initial begin
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        t_stage;
        t_live;
        t_reset;
        print_verdict;
    end
endmodule
